// ==== hw/dme_debug_match_event_logic.sv ====
// dme_debug_match_event_logic: comparators, event priority, sequencer, ahb-lite registers
//
// Notes on behaviour
// - opcode compare flags an instruction at execute, before it executes
// - opcode matches ignore data and the direction qualify settings
// - no comparison of core activity while the core is halted for debug
// - data match on address hit, optionally qualified by data and direction
// - data match breakpoint lands within two instructions of the access
// - after a change of flow the breakpoint address may lie elsewhere
// - opcode fetches never count as data accesses
// - synchronised external event pin can step the sequencer, enabled by config
// - external event in state mode acts through the channel 3 field
// - every external event in flag or state mode sets the external event flag
// - writing one to force bit goes Final then straight to State0
// - breakpoint issued on the move into Final, if enabled
// - coincident events: force, then channel 3, 1, 0; losers dropped
// - hardware disarm beats a simultaneous software arm write
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module dme_debug_match_event_logic (
	// clock and reset
	input  wire logic                          sys_clk,
	input  wire logic                          rst_n,
	// ahb-lite slave
	input  wire logic                          hsel,
	input  wire logic [dme_pkg::DME_OFS_W-1:0] haddr,
	input  wire logic [1:0]                    htrans,
	input  wire logic                          hwrite,
	input  wire logic [2:0]                    hsize,
	input  wire logic [dme_pkg::DME_HDATA_W-1:0] hwdata,
	input  wire logic                          hready,
	output logic                               hreadyout,
	output logic                               hresp,
	output logic [dme_pkg::DME_HDATA_W-1:0]    hrdata,
	// core side
	input  wire dme_pkg::dme_cpu_t             cpuBus,
	input  wire logic                          haltedDebugState,
	// pin
	input  wire logic                          externalEventInput,
	// results
	output logic                               breakpointReq,
	output dme_pkg::dme_state_t                seqState,
	output logic                               irq
);
	import dme_pkg::*;

	// bus data phase
	logic                 dphValid_reg;
	logic                 dphWrite_reg;
	logic [DME_OFS_W-1:0] dphAddr_reg;
	logic                 rdDone_reg;
	logic [DME_HDATA_W-1:0] hrdata_reg;
	// software state
	logic                  arm_reg, arm_next;
	logic                  bkEn_reg;
	logic [1:0]            eevCfg_reg;
	logic [DME_SC_W-1:0]   sc_reg [DME_NCH];
	logic [DME_EF_W-1:0]   flag_reg, flag_next;
	logic [DME_EF_W-1:0]   mask_reg;
	logic [DME_CC_W-1:0]   cmpCtrl_reg [DME_NCH];
	logic [DME_ADDR_W-1:0] cmpAddr_reg [DME_NCH];
	logic [DME_DATA_W-1:0] cmpData_reg [DME_NCH];
	// sequencer and pin
	dme_state_t state_reg, state_next;
	logic       brk_reg;
	logic       eevSync1_reg, eevSync2_reg, eevPrev_reg;

	// target field to state
	function automatic dme_state_t tgtState(input logic [2:0] f, input dme_state_t cur);
		case (f)
			DME_TGT_S1:    tgtState = DME_S1;
			DME_TGT_S2:    tgtState = DME_S2;
			DME_TGT_S3:    tgtState = DME_S3;
			DME_TGT_FINAL: tgtState = DME_FINAL;
			default:       tgtState = cur;
		endcase
	endfunction : tgtState

	// state to state control index
	function automatic logic [1:0] scIndex(input dme_state_t s);
		case (s)
			DME_S2:  scIndex = 2'h1;
			DME_S3:  scIndex = 2'h2;
			default: scIndex = 2'h0;
		endcase
	endfunction : scIndex

	// ahb decode; writes commit in the data phase, reads take one wait state
	wire        addrPhase = hsel & hready & htrans[1];
	wire        wrEn      = dphValid_reg & dphWrite_reg;
	wire        rdStall   = dphValid_reg & ~dphWrite_reg & ~rdDone_reg;
	wire [3:0]  page      = dphAddr_reg[7:4];
	wire [1:0]  sub       = dphAddr_reg[3:2];
	wire [3:0]  pageRel   = page - DME_CMP_PAGE0;
	wire        isCmp     = (pageRel < 4'(DME_NCH));
	wire [1:0]  chSel     = pageRel[1:0];
	wire        wrCtrl    = wrEn & (dphAddr_reg == DME_OFS_CTRL);
	wire        wrFlag    = wrEn & (dphAddr_reg == DME_OFS_FLAG);
	wire        wrMask    = wrEn & (dphAddr_reg == DME_OFS_MASK);
	wire        wrSc1     = wrEn & (dphAddr_reg == DME_OFS_SC1);
	wire        wrSc2     = wrEn & (dphAddr_reg == DME_OFS_SC2);
	wire        wrSc3     = wrEn & (dphAddr_reg == DME_OFS_SC3);
	wire        wrCmp     = wrEn & isCmp;
	wire        forceTrig = wrCtrl & hwdata[DME_C1_FORCE_BREAKPOINT_BIT];

	assign hreadyout = ~rdStall;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;

	// bus phase tracking
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dphValid_reg <= 1'b0;
			dphWrite_reg <= 1'b0;
			dphAddr_reg  <= '0;
			rdDone_reg   <= 1'b0;
		end else begin
			dphValid_reg <= addrPhase | (dphValid_reg & rdStall);
			rdDone_reg   <= rdStall;
			if (addrPhase) begin
				dphWrite_reg <= hwrite;
				dphAddr_reg  <= haddr;
			end
		end
	end

	// read selection, unmapped reads zero
	wire [DME_HDATA_W-1:0] rdCtrl  = DME_HDATA_W'({eevCfg_reg, bkEn_reg, 1'b0, arm_reg});
	wire [DME_HDATA_W-1:0] rdState = DME_HDATA_W'(state_reg);
	wire [DME_HDATA_W-1:0] rdCmp   = (sub == DME_CMP_CTRL) ? DME_HDATA_W'(cmpCtrl_reg[chSel]) :
	                                 (sub == DME_CMP_ADDR) ? DME_HDATA_W'(cmpAddr_reg[chSel]) :
	                                 (sub == DME_CMP_DATA) ? DME_HDATA_W'(cmpData_reg[chSel]) : '0;
	wire [DME_HDATA_W-1:0] rdMux   =
		(dphAddr_reg == DME_OFS_CTRL)  ? rdCtrl :
		(dphAddr_reg == DME_OFS_STATE) ? rdState :
		(dphAddr_reg == DME_OFS_SC1)   ? DME_HDATA_W'(sc_reg[0]) :
		(dphAddr_reg == DME_OFS_SC2)   ? DME_HDATA_W'(sc_reg[1]) :
		(dphAddr_reg == DME_OFS_SC3)   ? DME_HDATA_W'(sc_reg[2]) :
		(dphAddr_reg == DME_OFS_FLAG)  ? DME_HDATA_W'(flag_reg) :
		(dphAddr_reg == DME_OFS_MASK)  ? DME_HDATA_W'(mask_reg) :
		isCmp                          ? rdCmp : '0;

	// read data register, loaded in the wait cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			hrdata_reg <= '0;
		else if (rdStall)
			hrdata_reg <= rdMux;
	end

	// configuration registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bkEn_reg   <= 1'b0;
			eevCfg_reg <= DME_EEV_OFF;
			mask_reg   <= DME_RST_FLAG;
			sc_reg     <= '{default: DME_RST_SC};
		end else begin
			if (wrCtrl) begin
				bkEn_reg   <= hwdata[DME_C1_BKEN];
				eevCfg_reg <= hwdata[DME_C1_EEV +: 2];
			end
			if (wrMask) mask_reg  <= hwdata[DME_EF_W-1:0];
			if (wrSc1)  sc_reg[0] <= hwdata[DME_SC_W-1:0];
			if (wrSc2)  sc_reg[1] <= hwdata[DME_SC_W-1:0];
			if (wrSc3)  sc_reg[2] <= hwdata[DME_SC_W-1:0];
		end
	end

	// comparator registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmpCtrl_reg <= '{default: DME_RST_CC};
			cmpAddr_reg <= '{default: '0};
			cmpData_reg <= '{default: '0};
		end else if (wrCmp) begin
			if (sub == DME_CMP_CTRL) cmpCtrl_reg[chSel] <= hwdata[DME_CC_W-1:0];
			if (sub == DME_CMP_ADDR) cmpAddr_reg[chSel] <= hwdata[DME_ADDR_W-1:0];
			if (sub == DME_CMP_DATA) cmpData_reg[chSel] <= hwdata[DME_DATA_W-1:0];
		end
	end

	// comparators; opcode compare uses the execute-stage address
	logic [DME_NCH-1:0] opcMatch;
	logic [DME_NCH-1:0] datMatch;
	logic [DME_NCH-1:0] chMatch;
	for (genvar i = 0; i < DME_NCH; i++) begin : g_cmp
		wire en    = cmpCtrl_reg[i][DME_CC_EN] & ~haltedDebugState;
		wire opc   = cmpCtrl_reg[i][DME_CC_OPC];
		wire dirOk = ~cmpCtrl_reg[i][DME_CC_RWQ] |
		             (cmpCtrl_reg[i][DME_CC_RWV] == cpuBus.accWrite);
		wire datOk = ~cmpCtrl_reg[i][DME_CC_DQ] | (cpuBus.accData == cmpData_reg[i]);
		assign opcMatch[i] = en & opc & cpuBus.execValid &
		                     (cpuBus.execAddr == cmpAddr_reg[i]);
		assign datMatch[i] = en & ~opc & cpuBus.accValid & ~cpuBus.accFetch &
		                     (cpuBus.accAddr == cmpAddr_reg[i]) & dirOk & datOk;
		assign chMatch[i]  = opcMatch[i] | datMatch[i];
	end

	// external event pin synchroniser and edge
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			eevSync1_reg <= 1'b0;
			eevSync2_reg <= 1'b0;
			eevPrev_reg  <= 1'b0;
		end else begin
			eevSync1_reg <= externalEventInput;
			eevSync2_reg <= eevSync1_reg;
			eevPrev_reg  <= eevSync2_reg;
		end
	end
	wire eevEdge    = eevSync2_reg & ~eevPrev_reg;
	wire eevOn      = eevEdge & (eevCfg_reg != DME_EEV_OFF);
	wire extToState = eevEdge & (eevCfg_reg == DME_EEV_STATE);

	// priority: channel 3 (with external event), then 1, then 0
	wire                 ch3Evt   = chMatch[2] | extToState;
	wire [DME_SC_W-1:0]  scCur    = sc_reg[scIndex(state_reg)];
	wire [DME_SC_FW-1:0] fld3     = scCur[2*DME_SC_FW +: DME_SC_FW];
	wire [DME_SC_FW-1:0] winFld   = ch3Evt     ? fld3 :
	                                chMatch[1] ? scCur[DME_SC_FW +: DME_SC_FW] :
	                                chMatch[0] ? scCur[0 +: DME_SC_FW] : DME_TGT_NONE;
	wire                 stActive = (state_reg == DME_S1) | (state_reg == DME_S2) |
	                                (state_reg == DME_S3);
	wire                 hwDisarm = (state_reg == DME_FINAL);

	// sequencer next state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			DME_S0:    state_next = arm_reg ? DME_S1 : DME_S0;
			DME_S1,
			DME_S2,
			DME_S3:    state_next = !arm_reg ? DME_S0 : tgtState(winFld, state_reg);
			DME_FINAL: state_next = DME_S0;
			default:   state_next = DME_S0;
		endcase
		if (forceTrig && state_reg != DME_FINAL)
			state_next = DME_FINAL;
	end

	// arm: hardware disarm wins over a software arm write
	assign arm_next = hwDisarm ? 1'b0 : (wrCtrl ? hwdata[DME_C1_ARM] : arm_reg);

	// sequencer, arm and breakpoint pulse
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= DME_S0;
			arm_reg   <= 1'b0;
			brk_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			arm_reg   <= arm_next;
			brk_reg   <= (state_next == DME_FINAL) & bkEn_reg;
		end
	end

	// sticky flags, set wins over write-one clear
	wire [DME_EF_W-1:0] flagSet = {brk_reg, eevOn, chMatch[2], chMatch[1], chMatch[0]};
	wire [DME_EF_W-1:0] flagClr = wrFlag ? hwdata[DME_EF_W-1:0] : '0;
	assign flag_next = (flag_reg & ~flagClr) | flagSet;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			flag_reg <= DME_RST_FLAG;
		else
			flag_reg <= flag_next;
	end

	// outputs
	assign breakpointReq = brk_reg;
	assign seqState      = state_reg;
	assign irq           = |(flag_reg & mask_reg);

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence finalThenIdle;
		(state_reg == DME_FINAL) ##1 (state_reg == DME_S0);
	endsequence
	wire winFinal = arm_reg & stActive & ~forceTrig & (winFld == DME_TGT_FINAL);

	a_force_final_idle: assert property (forceTrig && state_reg != DME_FINAL |=> finalThenIdle)
		else $error("force bit did not pass Final into State0");
	a_brk_on_idle: assert property (brk_reg |-> finalThenIdle)
		else $error("breakpoint not on move into State0");
	a_halt_no_cmp: assert property (haltedDebugState |-> chMatch == '0)
		else $error("comparison while halted");
	a_fetch_no_data: assert property (cpuBus.accFetch |-> datMatch == '0)
		else $error("data match on opcode fetch");
	a_opc_dir_free: assert property (cmpCtrl_reg[0][DME_CC_EN] && cmpCtrl_reg[0][DME_CC_OPC] &&
		!haltedDebugState && cpuBus.execValid && cpuBus.execAddr == cmpAddr_reg[0]
		|-> opcMatch[0])
		else $error("opcode match blocked by direction or data");
	a_opc_brk_next: assert property (winFinal && bkEn_reg && opcMatch != '0 |=> brk_reg)
		else $error("opcode match breakpoint late");
	a_data_brk_bound: assert property (winFinal && bkEn_reg && datMatch != '0
		|-> ##[1:2] brk_reg)
		else $error("data match breakpoint too late");
	a_ext_flag_set: assert property (eevOn |=> flag_reg[DME_EF_EXT])
		else $error("external event flag not set");
	a_ext_as_ch3: assert property (extToState && arm_reg && stActive && !forceTrig
		&& fld3 == DME_TGT_FINAL |=> state_reg == DME_FINAL)
		else $error("external event did not act as channel 3");
	a_prio_ch3_wins: assert property (ch3Evt && chMatch[1] && arm_reg && stActive &&
		!forceTrig |=> state_reg == $past(tgtState(fld3, state_reg)))
		else $error("lower channel beat channel 3");
	a_disarm_wins: assert property (hwDisarm && wrCtrl && hwdata[DME_C1_ARM] |=> !arm_reg)
		else $error("software arm beat hardware disarm");
	a_idle_unarmed: assert property (!arm_reg && !forceTrig && state_reg != DME_FINAL
		|=> state_reg == DME_S0)
		else $error("sequencer moved while disarmed");
	a_flag_set_wins: assert property (wrFlag && hwdata[DME_EF_EXT] && eevOn
		|=> flag_reg[DME_EF_EXT])
		else $error("flag clear beat a new event");

endmodule : dme_debug_match_event_logic

// ==== hw/dme_pkg.sv ====
// dme_pkg: constants, types and register map of the debug match event logic
package dme_pkg;

	// bus and core widths
	localparam int DME_HDATA_W = 32;
	localparam int DME_ADDR_W  = 24;
	localparam int DME_DATA_W  = 32;
	localparam int DME_OFS_W   = 8;
	localparam int DME_NCH     = 3;  // index 0,1,2 = channel 0,1,3

	// register byte offsets
	localparam logic [7:0] DME_OFS_CTRL  = 8'h00;
	localparam logic [7:0] DME_OFS_STATE = 8'h04;
	localparam logic [7:0] DME_OFS_SC1   = 8'h08;
	localparam logic [7:0] DME_OFS_SC2   = 8'h0C;
	localparam logic [7:0] DME_OFS_SC3   = 8'h10;
	localparam logic [7:0] DME_OFS_FLAG  = 8'h14;
	localparam logic [7:0] DME_OFS_MASK  = 8'h18;
	localparam logic [3:0] DME_CMP_PAGE0 = 4'h2;  // comparator pages 0x20,0x30,0x40
	localparam logic [1:0] DME_CMP_CTRL  = 2'h0;
	localparam logic [1:0] DME_CMP_ADDR  = 2'h1;
	localparam logic [1:0] DME_CMP_DATA  = 2'h2;

	// debug_control_one fields
	localparam int DME_C1_ARM  = 0;
	localparam int DME_C1_FORCE_BREAKPOINT_BIT = 1;  // force_breakpoint_bit, reads zero
	localparam int DME_C1_BKEN = 2;
	localparam int DME_C1_EEV  = 3;  // external_event_config, two bits
	localparam int DME_C1_W    = 5;
	localparam logic [1:0] DME_EEV_OFF   = 2'h0;
	localparam logic [1:0] DME_EEV_FLAG  = 2'h1;
	localparam logic [1:0] DME_EEV_STATE = 2'h2;

	// comparator control fields
	localparam int DME_CC_EN  = 0;
	localparam int DME_CC_OPC = 1;  // opcode_compare_select
	localparam int DME_CC_RWQ = 2;  // access_direction_qualify_enable
	localparam int DME_CC_RWV = 3;  // direction to compare, 1 = write
	localparam int DME_CC_DQ  = 4;  // data value qualify enable
	localparam int DME_CC_W   = 5;

	// state_control_regs: one 3-bit target field per channel
	localparam int DME_SC_FW = 3;
	localparam int DME_SC_W  = DME_SC_FW * DME_NCH;
	localparam logic [2:0] DME_TGT_NONE  = 3'h0;
	localparam logic [2:0] DME_TGT_S1    = 3'h1;
	localparam logic [2:0] DME_TGT_S2    = 3'h2;
	localparam logic [2:0] DME_TGT_S3    = 3'h3;
	localparam logic [2:0] DME_TGT_FINAL = 3'h4;

	// event_flag_reg bits, mask has the same layout
	localparam int DME_EF_CH0 = 0;
	localparam int DME_EF_CH1 = 1;
	localparam int DME_EF_CH3 = 2;
	localparam int DME_EF_EXT = 3;  // external_event_flag
	localparam int DME_EF_BRK = 4;
	localparam int DME_EF_W   = 5;

	// reset values
	localparam logic [DME_EF_W-1:0] DME_RST_FLAG = 5'h00;
	localparam logic [DME_SC_W-1:0] DME_RST_SC   = 9'h000;
	localparam logic [DME_CC_W-1:0] DME_RST_CC   = 5'h00;

	// sequencer states, gray along S0-S1-S2-S3-Final
	typedef enum logic [2:0] {
		DME_S0    = 3'h0,
		DME_S1    = 3'h1,
		DME_S2    = 3'h3,
		DME_S3    = 3'h2,
		DME_FINAL = 3'h6
	} dme_state_t;

	// core activity seen by the comparators
	typedef struct packed {
		logic                  execValid;  // opcode entering execute stage
		logic [DME_ADDR_W-1:0] execAddr;
		logic                  accValid;   // bus access this cycle
		logic                  accFetch;   // access is an opcode fetch
		logic                  accWrite;
		logic [DME_ADDR_W-1:0] accAddr;
		logic [DME_DATA_W-1:0] accData;
	} dme_cpu_t;

endpackage : dme_pkg

// ==== testbench/dme_core_model.sv ====
// dme_core_model: core pipeline and data bus activity seen by the debug logic
`timescale 1ns/10ps
module dme_core_model import dme_pkg::*; (
	// clock
	input  wire logic        sys_clk,
	// core activity
	output dme_pkg::dme_cpu_t cpuBus
);
	// quiet core before the first instruction
	initial begin
		cpuBus = '0;
	end
	// one cycle of activity; then both valids drop and the other lines show the inverse of the last value
	task automatic act(input dme_cpu_t v);
		dme_cpu_t idl;
		cpuBus <= v;
		@(posedge sys_clk);
		idl = ~v;
		idl.execValid = 1'b0;
		idl.accValid = 1'b0;
		cpuBus <= idl;
	endtask : act
endmodule : dme_core_model

// ==== testbench/tb_top.sv ====
// tb_top: self-checking bench for the debug match event logic
`timescale 1ns/10ps
module tb_top;
	import dme_pkg::*;
	// one ordinary case: channel, comparator setup, activity kind, outcome
	typedef struct packed {
		logic [1:0] ch;
		logic [4:0] cc;
		logic [1:0] kind;  // 0 exec, 1 read, 2 write, 3 fetch
		logic       dm;
		logic       halt;
		logic       arm;
		logic       hit;
	} dme_row_t;
	localparam logic [23:0] CADDR = 24'h00_1234;
	localparam logic [31:0] CDATA = 32'hA5A5_0001;
	// bench signals
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        hsel = 1'b0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic        halted = 1'b0;
	logic        extPin = 1'b0;
	logic        hreadyout;
	logic        hresp;
	logic        breakpointReq;
	logic        irq;
	logic [31:0] hrdata;
	logic [31:0] rdat;
	dme_cpu_t    cpuBus;
	dme_cpu_t    v;
	dme_state_t  seqState;
	dme_row_t    r;
	int          failures = 0;
	int          checked = 0;
	int          n;
	logic [7:0]  ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h18, 8'h20, 8'h80};
	dme_row_t    rows [9] = '{
		'{2'd0, 5'h0F, 2'd0, 1'b1, 1'b0, 1'b1, 1'b1},
		'{2'd0, 5'h03, 2'd0, 1'b1, 1'b1, 1'b1, 1'b0},
		'{2'd1, 5'h01, 2'd1, 1'b1, 1'b0, 1'b1, 1'b1},
		'{2'd1, 5'h01, 2'd3, 1'b1, 1'b0, 1'b1, 1'b0},
		'{2'd2, 5'h11, 2'd2, 1'b1, 1'b0, 1'b1, 1'b1},
		'{2'd2, 5'h11, 2'd2, 1'b0, 1'b0, 1'b1, 1'b0},
		'{2'd1, 5'h0D, 2'd1, 1'b1, 1'b0, 1'b1, 1'b0},
		'{2'd1, 5'h0D, 2'd2, 1'b1, 1'b0, 1'b1, 1'b1},
		'{2'd0, 5'h03, 2'd0, 1'b1, 1'b0, 1'b0, 1'b0}
	};
	// free-running core clock
	always #5 sys_clk = ~sys_clk;
	// design and core model
	dme_debug_match_event_logic uut (
		.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cpuBus(cpuBus),
		.haltedDebugState(halted), .externalEventInput(extPin),
		.breakpointReq(breakpointReq), .seqState(seqState), .irq(irq));
	dme_core_model core (.sys_clk(sys_clk), .cpuBus(cpuBus));
	// verdict and end of run
	task automatic test_done();
		$display("checks %0d errors %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : test_done
	// compare and count
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic stchk(input dme_state_t e, input logic b);
		chk("state", 32'(seqState), 32'(e));
		chk("brk", 32'(breakpointReq), 32'(b));
	endtask : stchk
	// hold until hready is high at the coming edge, bounded
	task automatic wait_rdy();
		n = 0;
		@(negedge sys_clk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 20) begin
				failures++;
				test_done();
			end
			@(negedge sys_clk);
		end
		rdat = hrdata;
		@(posedge sys_clk);
	endtask : wait_rdy
	// single ahb-lite transfer, entered just after a rising edge
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask : wr
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0000_0000);
		chk(nm, rdat, e);
	endtask : rdchk
	function automatic logic [7:0] cmpReg(input logic [1:0] c, input logic [1:0] f);
		return {DME_CMP_PAGE0 + {2'b00, c}, f, 2'b00};
	endfunction : cmpReg
	function automatic dme_cpu_t mk(input logic [1:0] k, input logic [23:0] a,
		input logic [31:0] d);
		dme_cpu_t c;
		c = '0;
		c.execValid = (k == 2'd0);
		c.execAddr = a;
		c.accValid = (k != 2'd0);
		c.accFetch = (k == 2'd3);
		c.accWrite = (k == 2'd2);
		c.accAddr = a;
		c.accData = d;
		return c;
	endfunction : mk
	// main sequence
	initial begin
		@(posedge sys_clk);
		@(negedge sys_clk);
		stchk(DME_S0, 1'b0);
		chk("irq", 32'(irq), 32'h0000_0000);
		chk("hresp", 32'(hresp), 32'h0000_0000);
		@(posedge sys_clk);
		@(posedge sys_clk);
		rst_n <= 1'b1;
		wr(8'h80, 32'hFFFF_FFFF);
		for (int i = 0; i < 7; i++) begin
			rdchk("reset", ofs[i], 32'h0000_0000);
		end
		wr(DME_OFS_MASK, 32'h0000_0010);
		wr(DME_OFS_SC1, 32'h0000_0124);
		for (int i = 0; i < 9; i++) begin
			r = rows[i];
			for (int k = 0; k < 3; k++) begin
				wr(cmpReg(2'(k), DME_CMP_CTRL), (k == r.ch) ? 32'(r.cc) : 32'h0000_0000);
			end
			wr(cmpReg(r.ch, DME_CMP_ADDR), 32'(CADDR));
			wr(cmpReg(r.ch, DME_CMP_DATA), CDATA);
			wr(DME_OFS_CTRL, r.arm ? 32'h0000_0005 : 32'h0000_0000);
			@(posedge sys_clk);
			@(negedge sys_clk);
			stchk(r.arm ? DME_S1 : DME_S0, 1'b0);
			@(posedge sys_clk);
			halted <= r.halt;
			core.act(mk(r.kind, CADDR, r.dm ? CDATA : ~CDATA));
			@(negedge sys_clk);
			stchk(r.hit ? DME_FINAL : (r.arm ? DME_S1 : DME_S0), r.hit);
			@(negedge sys_clk);
			stchk(r.hit ? DME_S0 : (r.arm ? DME_S1 : DME_S0), 1'b0);
			chk("irq", 32'(irq), 32'(r.hit));
			@(posedge sys_clk);
			halted <= 1'b0;
			// with the sequencer disarmed an enabled comparator still flags its match; only the sequencer ignores it
			rdchk("flag", DME_OFS_FLAG, r.hit ? 32'h0000_0010 | (32'h1 << r.ch) :
				{31'h0, ~r.arm});
			rdchk("ctrl", DME_OFS_CTRL, r.hit ? 32'h0000_0004 : {29'h0, r.arm, 1'b0, r.arm});
			wr(DME_OFS_FLAG, 32'h0000_001F);
			wr(DME_OFS_CTRL, 32'h0000_0000);
		end
		// forced breakpoint while disarmed; break enable must stand before the force
		wr(DME_OFS_CTRL, 32'h0000_0004);
		wr(DME_OFS_CTRL, 32'h0000_0006);
		@(negedge sys_clk);
		stchk(DME_FINAL, 1'b1);
		@(negedge sys_clk);
		stchk(DME_S0, 1'b0);
		chk("irq", 32'(irq), 32'h0000_0001);
		@(posedge sys_clk);
		rdchk("ctrl", DME_OFS_CTRL, 32'h0000_0004);
		wr(DME_OFS_FLAG, 32'h0000_001F);
		@(negedge sys_clk);
		chk("irq", 32'(irq), 32'h0000_0000);
		@(posedge sys_clk);
		// coincident events, higher channel wins
		wr(DME_OFS_SC1, 32'h0000_001A);
		wr(DME_OFS_SC3, 32'h0000_0108);
		wr(cmpReg(2'd0, DME_CMP_CTRL), 32'h0000_0003);
		wr(cmpReg(2'd1, DME_CMP_CTRL), 32'h0000_0001);
		wr(DME_OFS_CTRL, 32'h0000_0005);
		@(posedge sys_clk);
		v = mk(2'd0, CADDR, CDATA);
		v.accValid = 1'b1;
		core.act(v);
		@(negedge sys_clk);
		stchk(DME_S3, 1'b0);
		@(posedge sys_clk);
		wr(cmpReg(2'd2, DME_CMP_CTRL), 32'h0000_0001);
		core.act(v);
		@(negedge sys_clk);
		stchk(DME_FINAL, 1'b1);
		@(posedge sys_clk);
		// arm write lands in the final-state cycle
		wr(DME_OFS_SC1, 32'h0000_0004);
		wr(DME_OFS_CTRL, 32'h0000_0005);
		@(posedge sys_clk);
		fork
			wr(DME_OFS_CTRL, 32'h0000_0005);
			core.act(mk(2'd0, CADDR, CDATA));
		join
		rdchk("ctrl", DME_OFS_CTRL, 32'h0000_0004);
		// external event in state mode, then flag-only mode
		wr(DME_OFS_SC1, 32'h0000_0100);
		wr(DME_OFS_FLAG, 32'h0000_001F);
		wr(DME_OFS_CTRL, 32'h0000_0015);
		@(posedge sys_clk);
		extPin <= 1'b1;
		n = 0;
		while (breakpointReq !== 1'b1) begin
			@(negedge sys_clk);
			n++;
			if (n > 10) begin
				failures++;
				test_done();
			end
		end
		chk("extbrk", 32'(breakpointReq), 32'h0000_0001);
		@(posedge sys_clk);
		extPin <= 1'b0;
		rdchk("flag", DME_OFS_FLAG, 32'h0000_0018);
		wr(DME_OFS_FLAG, 32'h0000_001F);
		wr(DME_OFS_CTRL, 32'h0000_000D);
		extPin <= 1'b1;
		repeat (8) @(posedge sys_clk);
		extPin <= 1'b0;
		@(negedge sys_clk);
		stchk(DME_S1, 1'b0);
		chk("irq", 32'(irq), 32'h0000_0000);
		@(posedge sys_clk);
		rdchk("flag", DME_OFS_FLAG, 32'h0000_0008);
		test_done();
	end
endmodule : tb_top
